// ==== include/erbc_defines.svh ====
`ifndef ERBC_DEFINES_SVH
`define ERBC_DEFINES_SVH

// register offsets (byte addresses, one word each)
`define ERBC_OFF_CON1 8'h00
`define ERBC_OFF_STAT 8'h04
`define ERBC_OFF_RXST 8'h08
`define ERBC_OFF_IRQ_STAT 8'h0C
`define ERBC_OFF_IRQ_MASK 8'h10

// control-one fields
`define ERBC_CON1_DEC_BIT 0
`define ERBC_CON1_AUTOFC_BIT 1
`define ERBC_CON1_ON_BIT 15

// status fields
`define ERBC_STAT_CNT_LSB 16
`define ERBC_STAT_MOD_BIT 7
`define ERBC_STAT_TX_BIT 6
`define ERBC_STAT_RX_BIT 5

// interrupt status and mask fields
`define ERBC_IRQ_PEND_BIT 0
`define ERBC_IRQ_SAT_BIT 1
`define ERBC_IRQ_WIDTH 2

// counter limits and reset values
`define ERBC_CNT_MAX 8'hFF
`define ERBC_CNT_ZERO 8'h00
`define ERBC_CNT_RESET 8'h00
`define ERBC_RXST_RESET 32'h0000_0000

`endif

// ==== include/erbc_pkg.sv ====
package erbc_pkg;

  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } erbc_bus_req_t;

  // activity inputs from the mac and dma
  typedef struct packed {
    logic tx_active;
    logic rx_active;
    logic transaction_open;
  } erbc_activity_t;

  // module-active tracker states, gray along off-on-draining
  typedef enum logic [1:0] {
    ERBC_OFF = 2'b00,
    ERBC_ON = 2'b01,
    ERBC_DRAIN = 2'b11
  } erbc_mod_state_t;

endpackage : erbc_pkg

// ==== src/erbc_sat_counter.sv ====
`timescale 1ns/1ps
`include "erbc_defines.svh"

module erbc_sat_counter #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys, // system clock
  input wire logic resetn, // sync reset, active low
  input wire logic clear, // synchronous clear to zero
  input wire logic inc_valid, // hardware add request
  input wire logic [WIDTH-1:0] inc_amount, // descriptors to add
  input wire logic dec, // software decrement pulse
  output logic [WIDTH-1:0] count // current count
);

  localparam logic [WIDTH:0] MAX_W = {1'b0, {WIDTH{1'b1}}};
  logic [WIDTH-1:0] count_ff;
  logic [WIDTH-1:0] nxt_count;
  logic [WIDTH:0] sum_w;
  logic do_inc;
  logic do_dec;

  // simultaneous add and decrement cancel: count holds
  assign do_inc = inc_valid && !dec;
  assign do_dec = dec && !inc_valid;
  assign sum_w = {1'b0, count_ff} + {1'b0, inc_amount};

  // saturate both ways instead of wrapping
  always_comb
  begin
    nxt_count = count_ff;
    if (clear)
      nxt_count = '0;
    else if (do_inc)
      nxt_count = (sum_w > MAX_W) ? {WIDTH{1'b1}} : sum_w[WIDTH-1:0];
    else if (do_dec && count_ff != '0)
      nxt_count = count_ff - 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      count_ff <= '0;
    else
      count_ff <= nxt_count;
  end

  assign count = count_ff;

endmodule : erbc_sat_counter

// ==== src/erbc_status.sv ====
`timescale 1ns/1ps
`include "erbc_defines.svh"

// Notes on behaviour
// - eight-bit buffer count in status bits 23..16, adds descriptors per packet
// - each decrement-bit write lowers the count by one
// - increment at 0xFF leaves the count at 0xFF
// - decrement at zero leaves the count at zero
// - increment and decrement in the same cycle leave count unchanged
// - with auto flow control, receive halts at 0xFF until decremented
// - without auto flow control, receive keeps running; count saturates
// - pending flag while count nonzero; interrupt only when enabled
// - any write to receive start address clears the count
// - switching module off keeps the count; decrement still works
// - module-active bit 7 set while on or finishing a transaction
// - transmit-active bit 6 shows transmit logic taking data
// - status bits 31..24 and 15..8 read as zero
// - transmit-active follows transmission, not transmit-done events
module erbc_status #(
  parameter int CNT_WIDTH = 8
) (
  input wire logic clk_sys, // system clock, 25 MHz
  input wire logic resetn, // sync reset, active low
  input wire logic [7:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after strobe
  input wire logic rx_pkt_done, // pulse: packet received ok
  input wire logic [CNT_WIDTH-1:0] rx_desc_used, // descriptors of that packet
  input wire logic tx_active, // transmit logic taking data
  input wire logic rx_active, // receive logic on a packet
  input wire logic transaction_open, // a bus transaction still pending
  output logic rx_halt, // stall receive logic
  output logic module_on, // control on bit
  output logic irq // level interrupt
);

  erbc_pkg::erbc_bus_req_t req;
  erbc_pkg::erbc_activity_t act;
  erbc_pkg::erbc_mod_state_t mod_state_ff;
  erbc_pkg::erbc_mod_state_t nxt_mod_state;

  logic [31:0] con1_ff;
  logic [31:0] rxst_ff;
  logic [`ERBC_IRQ_WIDTH-1:0] irq_stat_ff;
  logic [`ERBC_IRQ_WIDTH-1:0] irq_mask_ff;
  logic [`ERBC_IRQ_WIDTH-1:0] nxt_irq_stat;
  logic [`ERBC_IRQ_WIDTH-1:0] irq_events;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [31:0] stat_word;
  logic [CNT_WIDTH-1:0] buf_count;
  logic tx_active_ff;
  logic rx_active_ff;
  logic mod_active;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign act = '{tx_active: tx_active, rx_active: rx_active,
                 transaction_open: transaction_open};

  // address decode
  wire wr_con1 = req.wr && req.addr == `ERBC_OFF_CON1;
  wire wr_rxst = req.wr && req.addr == `ERBC_OFF_RXST;
  wire wr_istat = req.wr && req.addr == `ERBC_OFF_IRQ_STAT;
  wire wr_imask = req.wr && req.addr == `ERBC_OFF_IRQ_MASK;
  // decrement bit is write-only action, never stored
  wire dec_req = wr_con1 && req.wdata[`ERBC_CON1_DEC_BIT];
  wire auto_fc = con1_ff[`ERBC_CON1_AUTOFC_BIT];
  wire cnt_full = buf_count == {CNT_WIDTH{1'b1}};
  wire pending = buf_count != '0;
  // halting while full keeps the dma from overrunning software
  wire halt_w = auto_fc && cnt_full;
  // an increment offered while halted is dropped only at the source
  wire inc_take = rx_pkt_done;

  // count is not cleared by the on bit, only by rxst writes and reset
  erbc_sat_counter #(
    .WIDTH(CNT_WIDTH)
  ) u_cnt (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clear(wr_rxst),
    .inc_valid(inc_take),
    .inc_amount(rx_desc_used),
    .dec(dec_req),
    .count(buf_count)
  );

  // control, start address, mask registers
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      con1_ff <= 32'h0000_0000;
      rxst_ff <= `ERBC_RXST_RESET;
      irq_mask_ff <= '0;
    end
    else
    begin
      if (wr_con1)
        con1_ff <= req.wdata & ~(32'h0000_0001 << `ERBC_CON1_DEC_BIT);
      if (wr_rxst)
        rxst_ff <= req.wdata;
      if (wr_imask)
        irq_mask_ff <= req.wdata[`ERBC_IRQ_WIDTH-1:0];
    end
  end

  // module-active tracker: stays busy after off until transactions drain
  always_comb
  begin
    nxt_mod_state = mod_state_ff;
    case (mod_state_ff)
      erbc_pkg::ERBC_OFF:
        if (con1_ff[`ERBC_CON1_ON_BIT])
          nxt_mod_state = erbc_pkg::ERBC_ON;
      erbc_pkg::ERBC_ON:
        if (!con1_ff[`ERBC_CON1_ON_BIT])
          nxt_mod_state = act.transaction_open ? erbc_pkg::ERBC_DRAIN : erbc_pkg::ERBC_OFF;
      erbc_pkg::ERBC_DRAIN:
        if (con1_ff[`ERBC_CON1_ON_BIT])
          nxt_mod_state = erbc_pkg::ERBC_ON;
        else if (!act.transaction_open)
          nxt_mod_state = erbc_pkg::ERBC_OFF;
      default:
        nxt_mod_state = erbc_pkg::ERBC_OFF;
    endcase
  end

  assign mod_active = mod_state_ff != erbc_pkg::ERBC_OFF;

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      mod_state_ff <= erbc_pkg::ERBC_OFF;
    else
      mod_state_ff <= nxt_mod_state;
  end

  // activity flags are registered copies of live activity, not done events
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      tx_active_ff <= 1'b0;
      rx_active_ff <= 1'b0;
    end
    else
    begin
      tx_active_ff <= act.tx_active;
      rx_active_ff <= act.rx_active;
    end
  end

  // status word, unimplemented bits tied low
  always_comb
  begin
    stat_word = 32'h0000_0000;
    stat_word[`ERBC_STAT_CNT_LSB +: CNT_WIDTH] = buf_count;
    stat_word[`ERBC_STAT_MOD_BIT] = mod_active;
    stat_word[`ERBC_STAT_TX_BIT] = tx_active_ff;
    stat_word[`ERBC_STAT_RX_BIT] = rx_active_ff;
  end

  // sticky events: set each cycle the count is nonzero or at full
  assign irq_events[`ERBC_IRQ_PEND_BIT] = pending;
  assign irq_events[`ERBC_IRQ_SAT_BIT] = cnt_full;

  // set wins over a write-one clear in the same cycle
  always_comb
  begin
    nxt_irq_stat = irq_stat_ff;
    if (wr_istat)
      nxt_irq_stat = nxt_irq_stat & ~req.wdata[`ERBC_IRQ_WIDTH-1:0];
    nxt_irq_stat = nxt_irq_stat | irq_events;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      irq_stat_ff <= '0;
    else
      irq_stat_ff <= nxt_irq_stat;
  end

  // read mux, unmapped addresses read zero
  always_comb
  begin
    case (req.addr)
      `ERBC_OFF_CON1: nxt_rdata = con1_ff;
      `ERBC_OFF_STAT: nxt_rdata = stat_word;
      `ERBC_OFF_RXST: nxt_rdata = rxst_ff;
      `ERBC_OFF_IRQ_STAT: nxt_rdata = {30'h0000_0000, irq_stat_ff};
      `ERBC_OFF_IRQ_MASK: nxt_rdata = {30'h0000_0000, irq_mask_ff};
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      rdata_ff <= 32'h0000_0000;
    else
      rdata_ff <= req.rd ? nxt_rdata : 32'h0000_0000;
  end

  assign reg_rdata = rdata_ff;
  assign rx_halt = halt_w;
  assign module_on = con1_ff[`ERBC_CON1_ON_BIT];
  assign irq = |(irq_stat_ff & irq_mask_ff);

  // assertion helpers
  logic [CNT_WIDTH-1:0] cnt_prev_ff;
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      cnt_prev_ff <= '0;
    else
      cnt_prev_ff <= buf_count;
  end

  sequence both_req_s;
    rx_pkt_done && dec_req && !wr_rxst;
  endsequence

  sat_high_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (rx_pkt_done && !dec_req && !wr_rxst && cnt_full) |=> cnt_full)
    else $error("count wrapped from full");
  floor_zero_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (dec_req && !rx_pkt_done && !wr_rxst && buf_count == '0) |=> buf_count == '0)
    else $error("count wrapped below zero");
  dec_step_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (dec_req && !rx_pkt_done && !wr_rxst && pending) |=> buf_count == $past(buf_count) - 1'b1)
    else $error("decrement step wrong");
  cancel_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    both_req_s |=> $stable(buf_count))
    else $error("simultaneous inc and dec changed count");
  inc_add_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (rx_pkt_done && !dec_req && !wr_rxst && {1'b0, buf_count} + {1'b0, rx_desc_used} < 9'h0FF)
    |=> buf_count == cnt_prev_ff + $past(rx_desc_used))
    else $error("increment amount wrong");
  rxst_clear_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_rxst |=> buf_count == '0)
    else $error("rxst write did not clear count");
  halt_full_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    rx_halt |-> (auto_fc && buf_count == `ERBC_CNT_MAX))
    else $error("halt without full count under flow control");
  // a lone decrement from full must release the stall on the next cycle
  halt_resume_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (rx_halt && dec_req && !rx_pkt_done) |=> !rx_halt)
    else $error("receive not resumed after decrement");
  pend_irq_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (pending && irq_mask_ff[`ERBC_IRQ_PEND_BIT]) |=> irq)
    else $error("pending interrupt missing");
  stat_zero_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    $past(req.rd) && $past(req.addr) == `ERBC_OFF_STAT
    |-> reg_rdata[31:24] == 8'h00 && reg_rdata[15:8] == 8'h00)
    else $error("reserved status bits nonzero");
  mod_busy_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    module_on |=> mod_active)
    else $error("module-active low while on");

endmodule : erbc_status

// ==== dv/erbc_rx_dma_model.sv ====
`timescale 1ns/1ps

module erbc_rx_dma_model (
  input wire logic clk_sys, // system clock
  input wire logic resetn, // sync reset, active low
  input wire logic start, // begin one packet
  input wire logic [7:0] desc, // descriptors it uses
  input wire logic rx_halt, // stall from the block
  output logic rx_pkt_done, // one-cycle done pulse
  output logic [7:0] rx_desc_used, // valid with the pulse
  output logic rx_active // packet in progress
);
  logic [1:0] wait_ff;
  logic [7:0] desc_ff;

  // two busy cycles, then finish unless stalled
  always_ff @(posedge clk_sys)
  begin
    rx_pkt_done <= 1'b0;
    rx_desc_used <= ~rx_desc_used; // released bus keeps toggling
    if (!resetn)
    begin
      rx_active <= 1'b0;
      wait_ff <= 2'h0;
      rx_desc_used <= 8'h5a;
    end
    else if (start && !rx_active)
    begin
      rx_active <= 1'b1;
      wait_ff <= 2'h2;
      desc_ff <= desc;
    end
    else if (rx_active && wait_ff != 2'h0)
      wait_ff <= wait_ff - 2'h1;
    else if (rx_active && !rx_halt)
    begin
      rx_active <= 1'b0;
      rx_pkt_done <= 1'b1;
      rx_desc_used <= desc_ff;
    end
  end
endmodule : erbc_rx_dma_model

// ==== dv/eth_rx_buffer_count_status_tb.sv ====
`timescale 1ns/1ps
`include "erbc_defines.svh"

module eth_rx_buffer_count_status_tb;
  typedef struct packed {
    logic [7:0] desc;
    logic [7:0] ndec;
    logic [7:0] cnt;
  } erbc_row_t;

  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic tx_active = 1'b0;
  logic transaction_open = 1'b0;
  logic start = 1'b0;
  logic [7:0] desc = 8'h00;
  logic [31:0] reg_rdata, rd_word;
  logic [7:0] rx_desc_used;
  logic rx_pkt_done, rx_active, rx_halt, module_on, irq;
  int n_mismatch = 0;
  int n_checks = 0;
  int i;
  int k;
  // packet size, decrements, resulting count
  erbc_row_t rows [4] = '{'{8'h03, 8'h01, 8'h02}, '{8'h05, 8'h00, 8'h07},
                          '{8'h00, 8'h07, 8'h00}, '{8'h00, 8'h01, 8'h00}};

  always #20 clk_sys = ~clk_sys;

  erbc_status #(.CNT_WIDTH(8)) u_dut (.clk_sys(clk_sys), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_pkt_done(rx_pkt_done), .rx_desc_used(rx_desc_used),
    .tx_active(tx_active), .rx_active(rx_active), .transaction_open(transaction_open),
    .rx_halt(rx_halt), .module_on(module_on), .irq(irq));

  erbc_rx_dma_model u_dma (.clk_sys(clk_sys), .resetn(resetn), .start(start), .desc(desc),
    .rx_halt(rx_halt), .rx_pkt_done(rx_pkt_done), .rx_desc_used(rx_desc_used),
    .rx_active(rx_active));

  task automatic end_sim();
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // idle edge after each strobe so no strobe is set twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    rd_word = reg_rdata;
  endtask : rd

  task automatic rs(input string what, input logic [31:0] exp);
    rd(`ERBC_OFF_STAT);
    chk(what, exp, rd_word);
  endtask : rs

  // status word from count and {module, tx, rx}
  function automatic logic [31:0] stat(input logic [7:0] c, input logic [2:0] f);
    return {8'h00, c, 8'h00, f, 5'h00};
  endfunction : stat

  task automatic pkt(input logic [7:0] d);
    start <= 1'b1;
    desc <= d;
    @(posedge clk_sys);
    start <= 1'b0;
  endtask : pkt

  task automatic wait_done();
    for (k = 0; k < 50 && rx_pkt_done !== 1'b1; k++)
      @(posedge clk_sys);
    if (k == 50)
    begin
      n_mismatch++;
      $display("Error packet done expected 1 seen 0");
      end_sim();
    end
    @(posedge clk_sys);
  endtask : wait_done

  initial
  begin
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
    chk("halt", 32'h0000_0000, {31'h0000_0000, rx_halt});
    rs("status reset", 32'h0000_0000);
    wr(`ERBC_OFF_CON1, 32'h0000_8000);
    for (i = 0; i < 4; i++)
    begin
      if (rows[i].desc != 8'h00)
      begin
        pkt(rows[i].desc);
        wait_done();
      end
      repeat (rows[i].ndec) wr(`ERBC_OFF_CON1, 32'h0000_8001);
      rs("count row", stat(rows[i].cnt, 3'h4));
    end
    // decrement lands on the same edge as the increment
    pkt(8'h02);
    wait_done();
    pkt(8'h01);
    repeat (3) @(posedge clk_sys);
    wr(`ERBC_OFF_CON1, 32'h0000_8001);
    repeat (2) @(posedge clk_sys);
    rs("inc with dec", stat(8'h02, 3'h4));
    chk("irq masked", 32'h0000_0000, {31'h0000_0000, irq});
    wr(`ERBC_OFF_IRQ_MASK, 32'h0000_0001);
    chk("irq unmasked", 32'h0000_0001, {31'h0000_0000, irq});
    wr(`ERBC_OFF_RXST, 32'h1234_5678);
    rs("start write", stat(8'h00, 3'h4));
    rd(`ERBC_OFF_RXST);
    chk("start address", 32'h1234_5678, rd_word);
    // read data must fall back to zero one cycle later
    @(posedge clk_sys);
    chk("rdata idle", 32'h0000_0000, reg_rdata);
    wr(`ERBC_OFF_IRQ_STAT, 32'h0000_0001);
    chk("irq cleared", 32'h0000_0000, {31'h0000_0000, irq});
    pkt(8'hff);
    wait_done();
    pkt(8'h04);
    wait_done();
    rs("saturated", stat(8'hff, 3'h4));
    rd(`ERBC_OFF_IRQ_STAT);
    chk("irq status", 32'h0000_0003, rd_word);
    rd(`ERBC_OFF_IRQ_MASK);
    chk("irq mask", 32'h0000_0001, rd_word);
    chk("halt no fc", 32'h0000_0000, {31'h0000_0000, rx_halt});
    wr(`ERBC_OFF_CON1, 32'h0000_8002);
    chk("halt full", 32'h0000_0001, {31'h0000_0000, rx_halt});
    pkt(8'h01);
    repeat (20) @(posedge clk_sys);
    rs("stalled", stat(8'hff, 3'h5));
    wr(`ERBC_OFF_CON1, 32'h0000_8003);
    wait_done();
    rs("refilled", stat(8'hff, 3'h4));
    tx_active <= 1'b1;
    transaction_open <= 1'b1;
    wr(`ERBC_OFF_CON1, 32'h0000_0000);
    chk("module on", 32'h0000_0000, {31'h0000_0000, module_on});
    rs("draining", stat(8'hff, 3'h6));
    wr(`ERBC_OFF_CON1, 32'h0000_0001);
    rs("dec while off", stat(8'hfe, 3'h6));
    chk("irq pending", 32'h0000_0001, {31'h0000_0000, irq});
    tx_active <= 1'b0;
    transaction_open <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rs("idle", stat(8'hfe, 3'h0));
    rd(8'h20);
    chk("unmapped", 32'h0000_0000, rd_word);
    rd(`ERBC_OFF_CON1);
    chk("control", 32'h0000_0000, rd_word);
    // mid-run reset clears the count that switching off keeps
    resetn <= 1'b0;
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rs("after reset", 32'h0000_0000);
    chk("irq reset", 32'h0000_0000, {31'h0000_0000, irq});
    chk("halt reset", 32'h0000_0000, {31'h0000_0000, rx_halt});
    end_sim();
  end
endmodule : eth_rx_buffer_count_status_tb
